// File: sysbus_cfg_map.svh
// register offsets, field positions and reset values of the system bus configuration block
// assumes inclusion by the design files; the package does not include it
`ifndef SYSBUS_CFG_MAP_SVH
`define SYSBUS_CFG_MAP_SVH
// register index offsets (byte address = 4 * index)
`define BUS_CFG_IDX 16'hff00
`define STACK_PAGE_IDX 16'hff01
`define WAIT_CLK_IDX 16'hff02
`define INSTR_CTRL_IDX 16'hff03
// bus_and_chip_select_config fields
`define MODE_HI_POS 7
`define MODE_LO_POS 6
`define RSV_CFG5_POS 5
`define RSV_CFG4_POS 4
// wait_and_clock_control fields
`define RSV_WAIT7_POS 7
`define WAIT_LSB_POS 4
`define CLK_SEL_POS 3
`define FAST_OSC_POS 2
`define RSV_WAIT1_POS 1
`define RSV_WAIT0_POS 0
// reset values
`define CFG_RST_INT 8'h30
`define CFG_RST_EXT 8'hf1
`define STACK_PAGE_RST 8'h00
`define WAIT_CLK_RST 8'h0c
// edges the boot strap needs to cross the synchroniser
`define BOOT_SYNC_CNT 2'h2
// instruction window status bit in the extra register
`define INSTR_BLK_POS 0
`endif

// File: sysbus_cfg_pkg.sv
// types of the system bus configuration block
// numeric constants written inline, sysbus_cfg_map.svh not included
`default_nettype none
package sysbus_cfg_pkg;
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_INVALID = 2'b01,
      MODE_EXP_MIN = 2'b10,
      MODE_EXP_MAX = 2'b11
   } bus_mode_e;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_T3 = 2'b01,
      BUS_WAIT = 2'b10,
      BUS_T4 = 2'b11
   } bus_state_e;
endpackage
`default_nettype wire

// File: wait_inserter.sv
// wait state sequencer for one external bus cycle
// assumes the cpu bus unit pulses t3 reached and waits for done
`include "sysbus_cfg_map.svh"
`default_nettype none
module wait_inserter
   import sysbus_cfg_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // control
   input wire logic t3_in,
   input wire logic allow_in,
   input wire logic [2:0] wait_in,
   // result
   output logic stall_out,
   output logic t4_out
);
   bus_state_e st_ff;
   logic [3:0] cnt_ff;

   // R16: wait between T3 and T4
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ff <= BUS_IDLE;
         cnt_ff <= 4'h0;
      end else if (ce_in) begin
         case (st_ff)
            BUS_IDLE: begin
               if (t3_in) begin
                  st_ff <= BUS_T3;
               end
            end
            BUS_T3: begin
               // R10: twice code half states
               // R17: no wait when barred
               if (allow_in && wait_in != 3'h0) begin
                  cnt_ff <= {1'b0, wait_in} - 4'h1;
                  st_ff <= BUS_WAIT;
               end else begin
                  st_ff <= BUS_T4;
               end
            end
            BUS_WAIT: begin
               if (cnt_ff == 4'h0) begin
                  st_ff <= BUS_T4;
               end else begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
            end
            BUS_T4: begin
               st_ff <= BUS_IDLE;
            end
            default: begin
               st_ff <= BUS_IDLE;
            end
         endcase
      end
   end

   assign stall_out = (st_ff == BUS_T3) || (st_ff == BUS_WAIT);
   assign t4_out = (st_ff == BUS_T4);
endmodule
`default_nettype wire

// File: sysbus_cfg.sv
// system bus configuration registers behind a classic wishbone slave
// assumes one clock, cpu bus unit on same clock, boot strap pin asynchronous
//
// Overview of operation
// R1: mode field selects memory configuration
// R2: code 00 in external boot is expanded
// R3: mode resets by boot source
// R4: chip select enables route selects to pins
// R5: enable 0 resets to boot source
// R6: interrupts masked until both registers written
// R7: stack page write blocks one instruction
// R8: software keeps stack page in range
// R9: stack page unaffected by pointer carry
// R10: wait code gives twice value half states
// R11: wait field resets to zero
// R12: clock select resets to fast
// R13: fast oscillator enable resets on
// R14: software writes both registers at init
// R15: software loads pointer right after page
// R16: waits inserted between T3 and T4
// R17: no waits internal or slow clock
// R18: chip select only on external area
// R19: expanded modes give pins to bus
// R20: software never writes mode 01
`include "sysbus_cfg_map.svh"
`default_nettype none
module sysbus_cfg
   import sysbus_cfg_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // boot strap pin
   input wire logic external_rom_boot_in,
   // wishbone slave
   input wire logic cyc_in,
   input wire logic stb_in,
   input wire logic we_in,
   input wire logic [17:0] adr_in,
   input wire logic [3:0] sel_in,
   input wire logic [31:0] dat_in,
   output logic [31:0] dat_out,
   output logic ack_out,
   // cpu side
   input wire logic instr_end_in,
   input wire logic ext_access_in,
   input wire logic [3:0] ext_area_in,
   input wire logic t3_in,
   // outputs
   output logic irq_block_out,
   output logic [1:0] bus_mode_out,
   output logic bus_pins_out,
   output logic [3:0] chip_select_n_out,
   output logic [3:0] cs_pin_sel_out,
   output logic cpu_clock_select_out,
   output logic fast_oscillator_out,
   output logic wait_stall_out,
   output logic wait_t4_out
);
   logic boot_s1_ff;
   logic boot_s2_ff;
   logic [1:0] boot_cnt_ff;
   logic boot_cap_ff;
   logic boot_done_ff;
   logic [7:0] cfg_ff;
   logic [7:0] page_ff;
   logic [7:0] wclk_ff;
   logic cfg_wr_ff;
   logic page_wr_ff;
   logic instr_blk_ff;
   logic [15:0] idx;
   logic wr;
   logic rd;
   logic [7:0] nxt_rdata;
   logic stall_w;
   logic t4_w;
   bus_mode_e mode;

   assign idx = adr_in[17:2];
   assign wr = cyc_in && stb_in && we_in && sel_in[0] && !ack_out;
   assign rd = cyc_in && stb_in && !ack_out;

   // ==========================================
   // boot strap synchroniser; the capture is in the configuration register block
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         boot_s1_ff <= 1'b0;
         boot_s2_ff <= 1'b0;
      end else if (ce_in) begin
         boot_s1_ff <= external_rom_boot_in;
         boot_s2_ff <= boot_s1_ff;
      end
   end

   // ==========================================
   // configuration register
   // R3: mode reset by boot
   // R5: enable 0 reset by boot
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_ff <= `CFG_RST_INT;
         boot_cnt_ff <= 2'h0;
         boot_cap_ff <= 1'b0;
         boot_done_ff <= 1'b0;
      end else if (ce_in) begin
         if (!boot_done_ff) begin
            // strap only valid once through both flip-flops
            if (boot_cnt_ff == `BOOT_SYNC_CNT) begin
               boot_done_ff <= 1'b1;
               boot_cap_ff <= boot_s2_ff;
               if (boot_s2_ff) begin
                  cfg_ff <= `CFG_RST_EXT;
               end
            end else begin
               boot_cnt_ff <= boot_cnt_ff + 2'h1;
            end
         end else if (wr && idx == `BUS_CFG_IDX) begin
            // R4: enables read back
            cfg_ff <= dat_in[7:0];
         end
      end
   end

   // R1: mode decode
   // R2: 00 expanded on ext boot
   always_comb begin
      mode = bus_mode_e'(cfg_ff[`MODE_HI_POS:`MODE_LO_POS]);
      if (mode == MODE_SINGLE && boot_cap_ff) begin
         mode = MODE_EXP_MAX;
      end
   end

   // ==========================================
   // stack page and wait/clock registers
   // R9: page only changes by write
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         page_ff <= `STACK_PAGE_RST;
      end else if (ce_in && wr && idx == `STACK_PAGE_IDX) begin
         page_ff <= dat_in[7:0];
      end
   end

   // R11: wait zero at reset
   // R12: clock select reset fast
   // R13: oscillator reset on
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wclk_ff <= `WAIT_CLK_RST;
      end else if (ce_in && wr && idx == `WAIT_CLK_IDX) begin
         wclk_ff <= dat_in[7:0];
      end
   end

   // ==========================================
   // interrupt masking
   // R6: both writes unmask
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_wr_ff <= 1'b0;
         page_wr_ff <= 1'b0;
      end else if (ce_in && wr) begin
         if (idx == `BUS_CFG_IDX) begin
            cfg_wr_ff <= 1'b1;
         end else if (idx == `STACK_PAGE_IDX) begin
            page_wr_ff <= 1'b1;
         end
      end
   end

   // R7: one instruction block
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         instr_blk_ff <= 1'b0;
      end else if (ce_in) begin
         if (wr && idx == `STACK_PAGE_IDX) begin
            instr_blk_ff <= 1'b1;
         end else if (instr_end_in) begin
            instr_blk_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_block_out <= 1'b1;
      end else if (ce_in) begin
         irq_block_out <= !(cfg_wr_ff && page_wr_ff) || instr_blk_ff
            || (wr && idx == `STACK_PAGE_IDX);
      end
   end

   // ==========================================
   // wishbone read and ack
   always_comb begin
      nxt_rdata = 8'h00;
      if (idx == `BUS_CFG_IDX) begin
         nxt_rdata = cfg_ff;
      end else if (idx == `STACK_PAGE_IDX) begin
         nxt_rdata = page_ff;
      end else if (idx == `WAIT_CLK_IDX) begin
         nxt_rdata = wclk_ff;
      end else if (idx == `INSTR_CTRL_IDX) begin
         nxt_rdata = {7'h00, instr_blk_ff};
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_out <= 1'b0;
         dat_out <= 32'h0;
      end else if (ce_in) begin
         ack_out <= rd;
         if (rd && !we_in) begin
            dat_out <= {24'h000000, nxt_rdata};
         end
      end
   end

   // ==========================================
   // pin and bus outputs
   // R18: select only on external area
   // R19: pins to bus when expanded
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_mode_out <= 2'h0;
         bus_pins_out <= 1'b0;
         chip_select_n_out <= 4'hf;
         cs_pin_sel_out <= 4'h0;
         cpu_clock_select_out <= 1'b1;
         fast_oscillator_out <= 1'b1;
         wait_stall_out <= 1'b0;
         wait_t4_out <= 1'b0;
      end else if (ce_in) begin
         bus_mode_out <= mode;
         bus_pins_out <= (mode != MODE_SINGLE);
         cs_pin_sel_out <= cfg_ff[3:0];
         chip_select_n_out <= ~(cfg_ff[3:0] & ext_area_in & {4{ext_access_in}});
         cpu_clock_select_out <= wclk_ff[`CLK_SEL_POS];
         fast_oscillator_out <= wclk_ff[`FAST_OSC_POS];
         wait_stall_out <= stall_w;
         wait_t4_out <= t4_w;
      end
   end

   // R17: wait only external on fast clock
   wait_inserter u_wait (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .t3_in(t3_in),
      .allow_in(ext_access_in && wclk_ff[`CLK_SEL_POS] && mode != MODE_SINGLE),
      .wait_in(wclk_ff[6:4]),
      .stall_out(stall_w),
      .t4_out(t4_w)
   );

   // ==========================================
   // assertions
   property p_mask_init;
      @(posedge mclk_in) disable iff (!rst_n_in)
         ce_in && !cfg_wr_ff |=> irq_block_out;
   endproperty
   a_mask_init: assert property (p_mask_init) else $error("irq unmasked early"); // R6

   property p_page_block;
      @(posedge mclk_in) disable iff (!rst_n_in)
         ce_in && wr && idx == `STACK_PAGE_IDX |=> irq_block_out;
   endproperty
   a_page_block: assert property (p_page_block) else $error("page write not blocking"); // R7

   property p_page_hold;
      @(posedge mclk_in) disable iff (!rst_n_in)
         !(wr && idx == `STACK_PAGE_IDX) |=> $stable(page_ff);
   endproperty
   a_page_hold: assert property (p_page_hold) else $error("page changed"); // R9

   property p_mode_ext;
      @(posedge mclk_in) disable iff (!rst_n_in)
         ce_in && boot_done_ff && boot_cap_ff |=> bus_mode_out != 2'b00;
   endproperty
   a_mode_ext: assert property (p_mode_ext) else $error("single mode on ext boot"); // R2

   property p_cs_int;
      @(posedge mclk_in) disable iff (!rst_n_in)
         ce_in && !ext_access_in |=> chip_select_n_out == 4'hf;
   endproperty
   a_cs_int: assert property (p_cs_int) else $error("select on internal"); // R18

   property p_no_wait;
      @(posedge mclk_in) disable iff (!rst_n_in)
         ce_in && t3_in && !stall_w ##1 ce_in
            && (!ext_access_in || !wclk_ff[`CLK_SEL_POS]) |=> !stall_w;
   endproperty
   a_no_wait: assert property (p_no_wait) else $error("wait on internal"); // R17

   property p_pins;
      @(posedge mclk_in) disable iff (!rst_n_in)
         ce_in |=> bus_pins_out == ($past(mode) != MODE_SINGLE);
   endproperty
   a_pins: assert property (p_pins) else $error("pin mux wrong"); // R19

   property p_ack;
      @(posedge mclk_in) disable iff (!rst_n_in)
         ce_in && rd |=> ack_out;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack"); // R4
endmodule
`default_nettype wire

// File: ext_bus_model.sv
// external memory on the expansion bus: runs one cycle per go pulse
// assumes the configuration block answers each t3 with a t4 pulse
`default_nettype none
module ext_bus_model (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // request from bench, t4 from the configuration block
   input wire logic go_in,
   input wire logic [3:0] area_in,
   input wire logic t4_in,
   // cpu bus side
   output logic ext_access_out,
   output logic [3:0] area_out,
   output logic t3_out
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_access_out <= 1'b0;
         area_out <= 4'h0;
         t3_out <= 1'b0;
      end else begin
         t3_out <= go_in;
         if (go_in) begin
            ext_access_out <= 1'b1;
            area_out <= area_in;
         end else if (t4_in) begin
            ext_access_out <= 1'b0;
            area_out <= 4'h0;
         end
      end
   end
endmodule
`default_nettype wire

// File: test_system_bus_configuration.sv
// bench for the system bus configuration block
// assumes the design files and the external bus model are compiled first
`default_nettype none
module test_system_bus_configuration
   import sysbus_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in = 0;
   logic rst_n_in = 0;
   logic boot = 0, cyc = 0, stb = 0, we = 0, instr_end = 0, go = 0;
   logic [17:0] adr = '0;
   logic [31:0] dat_w = '0;
   logic [31:0] dat_r;
   logic [3:0] area = '0;
   logic ack, ext_acc, t3, irq_block, pins, clksel, osc, stall, t4;
   logic [3:0] ext_area, csn, cssel, sn, a;
   logic [1:0] mode;
   logic [7:0] rd;
   int num_errors = 0, checks_done = 0, st;

   initial forever #4 mclk_in = ~mclk_in;

   sysbus_cfg dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
      .external_rom_boot_in(boot), .cyc_in(cyc), .stb_in(stb), .we_in(we),
      .adr_in(adr), .sel_in(4'h1), .dat_in(dat_w), .dat_out(dat_r), .ack_out(ack),
      .instr_end_in(instr_end), .ext_access_in(ext_acc), .ext_area_in(ext_area),
      .t3_in(t3), .irq_block_out(irq_block), .bus_mode_out(mode), .bus_pins_out(pins),
      .chip_select_n_out(csn), .cs_pin_sel_out(cssel), .cpu_clock_select_out(clksel),
      .fast_oscillator_out(osc), .wait_stall_out(stall), .wait_t4_out(t4));

   ext_bus_model mem_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .go_in(go),
      .area_in(area), .t4_in(t4), .ext_access_out(ext_acc), .area_out(ext_area),
      .t3_out(t3));

   // ==========================================
   // tasks
   task test_done;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      int n;
      @(posedge mclk_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      dat_w <= {24'h0, d};
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
         if (n > 20) begin
            num_errors++;
            test_done;
         end
      end while (ack !== 1'b1);
      rd = dat_r[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(negedge mclk_in);
   endtask

   task rdchk(input string what, input logic [15:0] idx, input logic [7:0] exp);
      wb(1'b0, idx, 8'h00);
      chk(what, {24'h0, exp}, {24'h0, rd});
   endtask

   task end_instr;
      @(posedge mclk_in);
      instr_end <= 1'b1;
      @(posedge mclk_in);
      instr_end <= 1'b0;
      repeat (2) @(posedge mclk_in);
   endtask

   task ext_cycle(input logic [3:0] ar);
      int n;
      @(posedge mclk_in);
      area <= ar;
      go <= 1'b1;
      @(posedge mclk_in);
      go <= 1'b0;
      st = 0;
      sn = 4'hf;
      n = 0;
      do begin
         @(negedge mclk_in);
         if (stall === 1'b1) st++;
         sn &= csn;
         n++;
         if (n > 60) begin
            num_errors++;
            test_done;
         end
      end while (t4 !== 1'b1);
      repeat (2) @(posedge mclk_in);
   endtask

   task do_reset(input logic b);
      @(posedge mclk_in);
      rst_n_in <= 1'b0;
      boot <= b;
      repeat (12) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      repeat (5) @(posedge mclk_in);
   endtask

   // ==========================================
   // main sequence
   initial begin
      do_reset(1'b0);
      rdchk("cfg", 16'hff00, 8'h30);
      chk("mode", 2'b00, mode);
      chk("pins", 1'b0, pins);
      chk("irq", 1'b1, irq_block);
      chk("clk", 2'b11, {clksel, osc});
      rdchk("page", 16'hff01, 8'h00);
      rdchk("wait", 16'hff02, 8'h0c);
      rdchk("unmapped", 16'hff10, 8'h00);
      wb(1'b1, 16'hff00, 8'hcf);
      repeat (3) @(posedge mclk_in);
      chk("irq cfg only", 1'b1, irq_block);
      wb(1'b1, 16'hff01, 8'h17);
      repeat (3) @(posedge mclk_in);
      chk("irq page", 1'b1, irq_block);
      rdchk("blk set", 16'hff03, 8'h01);
      end_instr;
      chk("irq open", 1'b0, irq_block);
      rdchk("blk clr", 16'hff03, 8'h00);
      rdchk("cfg rb", 16'hff00, 8'hcf);
      chk("mode max", 2'b11, mode);
      chk("pins exp", 1'b1, pins);
      chk("cs sel", 4'hf, cssel);
      wb(1'b1, 16'hff00, 8'h8f);
      chk("mode min", 2'b10, mode);
      rdchk("page rb", 16'hff01, 8'h17);
      for (int c = 0; c < 8; c++) begin
         wb(1'b1, 16'hff02, {1'b0, c[2:0], 4'hc});
         a = 4'h1 << c[1:0];
         ext_cycle(a);
         chk("stalls", c + 1, st);
         chk("cs", {28'h0, ~a}, {28'h0, sn});
      end
      wb(1'b1, 16'hff02, 8'h74);
      chk("slow", 2'b01, {clksel, osc});
      ext_cycle(4'h2);
      chk("slow stalls", 1, st);
      wb(1'b1, 16'hff00, 8'h8e);
      chk("cs0 off", 4'he, cssel);
      ext_cycle(4'h1);
      chk("cs0 quiet", 4'hf, sn);
      wb(1'b1, 16'hff01, 8'h00);
      repeat (2) @(posedge mclk_in);
      chk("irq again", 1'b1, irq_block);
      end_instr;
      chk("irq again open", 1'b0, irq_block);
      do_reset(1'b1);
      rdchk("cfg ext", 16'hff00, 8'hf1);
      chk("cs sel ext", 4'h1, cssel);
      chk("irq ext", 1'b1, irq_block);
      wb(1'b1, 16'hff00, 8'h01);
      chk("mode ext 00", 2'b11, mode);
      test_done;
   end
endmodule
`default_nettype wire
